// File: core/isadio_core.sv
// 24-point digital i/o block behind an 8-bit isa-style i/o bus
`default_nettype none
module isadio_core (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // host bus (asynchronous strobes)
   input wire logic [9:0] bus_addr,
   input wire logic bus_ior_n,
   input wire logic bus_iow_n,
   input wire logic bus_aen,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   output logic bus_rdata_oe,
   // jumpers
   input wire logic [4:0] jumpers,
   // ports
   output logic [7:0] first_port_out,
   input wire logic [7:0] second_port_in,
   output logic [7:0] second_port_out,
   output logic [7:0] second_port_oe,
   input wire logic [7:0] third_port_in,
   output logic [7:0] third_port_out,
   output logic [7:0] third_port_oe,
   // interrupt lines
   output logic irq5,
   output logic irq6,
   output logic irq7,
   output logic irq9
);
   ////////////////////////////////////////////////////////////////////////
   // synchronisers for every pin input
   localparam int SYNC_W = 10 + 3 + 8 + 5 + 8 + 8;
   logic [SYNC_W-1:0] raw;
   logic [SYNC_W-1:0] syn;
   assign raw = {bus_addr, bus_ior_n, bus_iow_n, bus_aen, bus_wdata, jumpers,
      second_port_in, third_port_in};

   isadio_sync #(.W(SYNC_W)) u_sync (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .d(raw),
      .q(syn)
   );

   isadio_pkg::isadio_bus_s bus;
   isadio_pkg::isadio_jumpers_s jmp;
   logic [7:0] second_pins;
   logic [7:0] third_pins;
   assign bus = isadio_pkg::isadio_bus_s'(syn[SYNC_W-1 -: 21]);
   assign jmp = isadio_pkg::isadio_jumpers_s'(syn[20:16]);
   assign second_pins = syn[15:8];
   assign third_pins = syn[7:0];

   ////////////////////////////////////////////////////////////////////////
   // address decode
   // base from the address jumpers
   function automatic logic [9:0] base_of(input logic hi, input logic lo);
      case ({hi, lo})
         2'b00: base_of = isadio_pkg::BASE_NONE;
         2'b01: base_of = isadio_pkg::BASE_LOW;
         2'b10: base_of = isadio_pkg::BASE_HIGH;
         default: base_of = isadio_pkg::BASE_BOTH;
      endcase
   endfunction : base_of

   logic [9:0] base;
   logic hit;
   logic [2:0] off;
   assign base = base_of(jmp.address_select_jumper_high, jmp.address_select_jumper_low);
   // eight byte locations; aen high marks a dma cycle and is not ours
   assign hit = !bus.aen && (bus.addr[9:3] == base[9:3]);
   assign off = bus.addr[2:0];

   // strobe edge detect on synchronised levels: one action per bus cycle
   logic iow_n_q;
   logic wr_pulse;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         iow_n_q <= 1'b1;
      end else begin
         iow_n_q <= bus.iow_n;
      end
   end
   // write taken on the falling edge of the write strobe
   assign wr_pulse = iow_n_q && !bus.iow_n && hit;

   ////////////////////////////////////////////////////////////////////////
   // reset-time jumper capture
   // jumpers only settle through the synchroniser, so the direction and
   // first-port reset level are loaded a few cycles after release
   logic [1:0] boot_cnt_q;
   logic boot_done_q;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         boot_cnt_q <= 2'd0;
         boot_done_q <= 1'b0;
      end else if (!boot_done_q) begin
         boot_cnt_q <= boot_cnt_q + 2'd1;
         boot_done_q <= (boot_cnt_q == 2'd2);
      end
   end
   logic boot_load;
   assign boot_load = !boot_done_q && (boot_cnt_q == 2'd2);

   ////////////////////////////////////////////////////////////////////////
   // interrupt control register
   logic [7:0] irq_ctrl_q;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irq_ctrl_q <= isadio_pkg::RST_ZERO;
      end else if (wr_pulse && off == isadio_pkg::OFF_IRQ_CTRL) begin
         irq_ctrl_q <= bus.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // direction register
   logic [1:0] dir_q;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         dir_q <= 2'b00;
      end else if (boot_load) begin
         dir_q <= {jmp.second_port_direction_jumper, jmp.third_port_direction_jumper};
      end else if (wr_pulse && off == isadio_pkg::OFF_DIR) begin
         dir_q <= bus.wdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // port data latches
   logic [7:0] first_q;
   logic [7:0] second_q;
   logic [7:0] third_q;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         first_q <= isadio_pkg::RST_ZERO;
      end else if (boot_load) begin
         first_q <= jmp.first_port_reset_level_jumper ? isadio_pkg::RST_ONES
            : isadio_pkg::RST_ZERO;
      end else if (wr_pulse && off == isadio_pkg::OFF_FIRST) begin
         first_q <= bus.wdata;
      end
   end

   // second and third latches reset low so outputs come up low
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         second_q <= isadio_pkg::RST_ZERO;
         third_q <= isadio_pkg::RST_ZERO;
      end else if (wr_pulse) begin
         if (off == isadio_pkg::OFF_SECOND) begin
            second_q <= bus.wdata;
         end
         if (off == isadio_pkg::OFF_THIRD) begin
            third_q <= bus.wdata;
         end
      end
   end
   // writes to offsets 0..2 fall through every decode above

   ////////////////////////////////////////////////////////////////////////
   // port pin drivers
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         first_port_out <= isadio_pkg::RST_ZERO;
         second_port_out <= isadio_pkg::RST_ZERO;
         second_port_oe <= isadio_pkg::RST_ZERO;
         third_port_out <= isadio_pkg::RST_ZERO;
         third_port_oe <= isadio_pkg::RST_ZERO;
      end else begin
         first_port_out <= first_q;
         second_port_out <= second_q;
         second_port_oe <= {8{dir_q[isadio_pkg::DIR_SECOND_BIT]}};
         third_port_out <= third_q;
         third_port_oe <= {8{dir_q[isadio_pkg::DIR_THIRD_BIT]}};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data
   // input pins read live, outputs read their latch
   function automatic logic [7:0] port_view(input logic out_en, input logic [7:0] latch,
                                            input logic [7:0] pins);
      port_view = out_en ? latch : pins;
   endfunction : port_view

   logic [7:0] rdata_d;
   always_comb begin
      rdata_d = isadio_pkg::RST_ZERO;
      case (off)
         isadio_pkg::OFF_ID: rdata_d = isadio_pkg::BOARD_ID;
         isadio_pkg::OFF_RSVD: rdata_d = isadio_pkg::RST_ZERO;
         isadio_pkg::OFF_JUMPER: rdata_d = {3'b000, jmp};
         isadio_pkg::OFF_IRQ_CTRL: rdata_d = irq_ctrl_q;
         isadio_pkg::OFF_DIR: rdata_d = {6'b00_0000, dir_q};
         isadio_pkg::OFF_FIRST: rdata_d = first_q;
         isadio_pkg::OFF_SECOND: rdata_d = port_view(dir_q[isadio_pkg::DIR_SECOND_BIT],
            second_q, second_pins);
         isadio_pkg::OFF_THIRD: rdata_d = port_view(dir_q[isadio_pkg::DIR_THIRD_BIT],
            third_q, third_pins);
         default: rdata_d = isadio_pkg::RST_ZERO;
      endcase
   end

   // data bus driven only while a read of our window is in progress
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         bus_rdata <= isadio_pkg::RST_ZERO;
         bus_rdata_oe <= 1'b0;
      end else begin
         bus_rdata <= rdata_d;
         bus_rdata_oe <= hit && !bus.ior_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt routing
   // only the low four third-port pins can interrupt
   logic [3:0] route;
   logic [3:0] pol;
   logic raw5;
   logic raw6;
   logic raw7;
   assign route = irq_ctrl_q[isadio_pkg::IRQ_ROUTE_LSB +: 4];
   assign pol = irq_ctrl_q[isadio_pkg::IRQ_POL_LSB +: 4];
   assign raw5 = route[0] & third_pins[0];
   assign raw6 = route[1] & third_pins[1];
   // pins 2 and 3 share irq7
   assign raw7 = (route[2] & third_pins[2]) | (route[3] & third_pins[3]);

   // polarity applied after routing; irq9 has no source so it just
   // idles at its polarity bit
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irq5 <= 1'b0;
         irq6 <= 1'b0;
         irq7 <= 1'b0;
         irq9 <= 1'b0;
      end else begin
         irq5 <= raw5 ^ pol[0];
         irq6 <= raw6 ^ pol[1];
         irq7 <= raw7 ^ pol[2];
         irq9 <= pol[3];
      end
   end
endmodule : isadio_core
`default_nettype wire

// File: core/isadio_sync.sv
// two-flop synchroniser for a vector of pin levels
`default_nettype none
module isadio_sync #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   // first stage feeds only the second
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : isadio_sync
`default_nettype wire

// File: inc/isadio_pkg.sv
// package: register map, field positions and reset values of the 24-point digital i/o block
`default_nettype none
package isadio_pkg;
   // register offsets from the jumper-selected base
   localparam logic [2:0] OFF_ID = 3'h0;
   localparam logic [2:0] OFF_RSVD = 3'h1;
   localparam logic [2:0] OFF_JUMPER = 3'h2;
   localparam logic [2:0] OFF_IRQ_CTRL = 3'h3;
   localparam logic [2:0] OFF_DIR = 3'h4;
   localparam logic [2:0] OFF_FIRST = 3'h5;
   localparam logic [2:0] OFF_SECOND = 3'h6;
   localparam logic [2:0] OFF_THIRD = 3'h7;
   // base address choices, indexed by {high jumper, low jumper}
   localparam logic [9:0] BASE_NONE = 10'h100;
   localparam logic [9:0] BASE_LOW = 10'h108;
   localparam logic [9:0] BASE_HIGH = 10'h110;
   localparam logic [9:0] BASE_BOTH = 10'h118;
   // board identifier: value is arbitrary
   localparam logic [7:0] BOARD_ID = 8'hA5;
   // direction register field positions
   localparam int DIR_THIRD_BIT = 0;
   localparam int DIR_SECOND_BIT = 1;
   // interrupt control field positions
   localparam int IRQ_ROUTE_LSB = 0;
   localparam int IRQ_POL_LSB = 4;
   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_ONES = 8'hFF;
   // jumper bundle
   typedef struct packed {
      logic first_port_reset_level_jumper;
      logic second_port_direction_jumper;
      logic third_port_direction_jumper;
      logic address_select_jumper_high;
      logic address_select_jumper_low;
   } isadio_jumpers_s;
   // host bus request
   typedef struct packed {
      logic [9:0] addr;
      logic ior_n;
      logic iow_n;
      logic aen;
      logic [7:0] wdata;
   } isadio_bus_s;
endpackage : isadio_pkg
`default_nettype wire

// File: verification/isadio_checker.sv
// assertion checker for the digital i/o core, bound to its ports
`default_nettype none
module isadio_checker (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // host bus and jumpers
   input wire logic [9:0] bus_addr,
   input wire logic bus_ior_n,
   input wire logic bus_iow_n,
   input wire logic bus_aen,
   input wire logic [7:0] bus_rdata,
   input wire logic bus_rdata_oe,
   input wire logic [4:0] jumpers,
   // ports and interrupt
   input wire logic [7:0] first_port_out,
   input wire logic [7:0] second_port_out,
   input wire logic [7:0] second_port_oe,
   input wire logic [7:0] third_port_out,
   input wire logic [7:0] third_port_oe,
   input wire logic irq9
);
   logic [3:0] since_rst_q;
   logic [9:0] base;
   logic hit;
   logic settled;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   //////////////////////////////////////////////////////////////////////////
   // cycles since release: jumper capture moves outputs early, so skip that
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         since_rst_q <= 4'h0;
      end else if (since_rst_q != 4'hF) begin
         since_rst_q <= since_rst_q + 4'h1;
      end
   end
   // decode window worked out from the two address jumpers
   assign base = 10'h100 + {5'h00, jumpers[1:0], 3'h0};
   assign hit = (bus_addr[9:3] == base[9:3]) && !bus_aen;
   assign settled = (since_rst_q == 4'hF);
   //////////////////////////////////////////////////////////////////////////
   rd_enable_a: assert property ($rose(bus_rdata_oe) |-> !bus_ior_n && hit)
      else $error("read data driven without a decoded read");
   id_read_a: assert property (bus_rdata_oe && $past(bus_addr, 3) == bus_addr
      && bus_addr[2:0] == 3'h0 |-> bus_rdata == isadio_pkg::BOARD_ID)
      else $error("identifier read wrong");
   jumper_read_a: assert property (bus_rdata_oe && $past(bus_addr, 3) == bus_addr
      && bus_addr[2:0] == 3'h2 |-> bus_rdata == {3'h0, jumpers})
      else $error("jumper status read wrong");
   dir_uniform_a: assert property (second_port_oe == {8{second_port_oe[0]}}
      && third_port_oe == {8{third_port_oe[0]}})
      else $error("port direction not uniform");
   second_write_a: assert property ($changed(second_port_out) && settled
      |-> !bus_iow_n && hit && bus_addr[2:0] == 3'h6)
      else $error("second port changed without its write");
   third_write_a: assert property ($changed(third_port_out) && settled
      |-> !bus_iow_n && hit && bus_addr[2:0] == 3'h7)
      else $error("third port changed without its write");
   dir_write_a: assert property ($changed({second_port_oe, third_port_oe}) && settled
      |-> !bus_iow_n && hit && bus_addr[2:0] == 3'h4)
      else $error("direction changed without its write");
   irq9_write_a: assert property ($changed(irq9) && settled
      |-> !bus_iow_n && hit && bus_addr[2:0] == 3'h3)
      else $error("irq9 changed without a control write");
   first_level_a: assert property (since_rst_q == 4'h8
      |-> first_port_out == {8{jumpers[4]}})
      else $error("first port reset level wrong");
   reset_low_a: assert property (since_rst_q == 4'h8
      |-> (second_port_out | third_port_out) == 8'h00)
      else $error("port outputs not low after reset");
endmodule : isadio_checker
bind isadio_core isadio_checker isadio_checker_i (.clk_sys, .arst_n, .bus_addr, .bus_ior_n,
   .bus_iow_n, .bus_aen, .bus_rdata, .bus_rdata_oe, .jumpers, .first_port_out,
   .second_port_out, .second_port_oe, .third_port_out, .third_port_oe, .irq9);
`default_nettype wire

// File: verification/isadio_host.sv
// host bus model: single-byte reads and writes with held strobes
`default_nettype none
module isadio_host (
   // clock
   input wire logic clk_sys,
   // device answer
   input wire logic [7:0] bus_rdata,
   input wire logic bus_rdata_oe,
   // bus request
   output var isadio_pkg::isadio_bus_s bus
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus with both strobes high
   initial bus = '{addr: 10'h000, ior_n: 1'b1, iow_n: 1'b1, aen: 1'b0, wdata: 8'h00};
   // strobe held five cycles: taken on the third edge, pins settle by the fifth
   task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic dma);
      @(posedge clk_sys);
      bus.addr <= a;
      bus.wdata <= d;
      bus.aen <= dma;
      bus.iow_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      bus.iow_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      bus.wdata <= ~d; // released data must not look like the old byte
      bus.aen <= 1'b0;
   endtask : wr
   // read data taken at the last edge of the held strobe
   task automatic rd(input logic [9:0] a, input logic dma, output logic [7:0] d,
                     output logic oe);
      @(posedge clk_sys);
      bus.addr <= a;
      bus.aen <= dma;
      bus.ior_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      d = bus_rdata;
      oe = bus_rdata_oe;
      bus.ior_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      bus.aen <= 1'b0;
   endtask : rd
endmodule : isadio_host
`default_nettype wire

// File: verification/tb.sv
// self-checking bench for the digital i/o core
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [2:0] off; logic [7:0] wd; logic [7:0] exp;} isadio_row_s;
   logic clk_sys, arst_n, bus_rdata_oe, irq5, irq6, irq7, irq9;
   logic [4:0] jumpers;
   logic [7:0] second_port_in, third_port_in, bus_rdata, first_port_out;
   logic [7:0] second_port_out, second_port_oe, third_port_out, third_port_oe;
   isadio_pkg::isadio_bus_s bus;
   int failures = 0;
   int compares = 0;
   logic [4:0] jmp [4] = '{5'h00, 5'h1D, 5'h16, 5'h0B};
   isadio_row_s rows [8] = '{'{3'h5, 8'h3C, 8'h3C}, '{3'h4, 8'h03, 8'h03},
      '{3'h6, 8'h5A, 8'h5A}, '{3'h7, 8'hC3, 8'hC3}, '{3'h3, 8'h0F, 8'h0F},
      '{3'h0, 8'h12, isadio_pkg::BOARD_ID}, '{3'h2, 8'hFF, 8'h0B}, '{3'h1, 8'h77, 8'h00}};
   // control byte, third port pins, expected {irq5, irq6, irq7, irq9}
   logic [19:0] irqs [8] = '{20'h0_1018, 20'h0_2024, 20'h0_4042, 20'h0_8082,
      20'h1_1008, 20'h2_2004, 20'h4_4002, 20'h8_0001};
   //////////////////////////////////////////////////////////////////////////
   isadio_core isadio_core_i (.clk_sys(clk_sys), .arst_n(arst_n), .bus_addr(bus.addr),
      .bus_ior_n(bus.ior_n), .bus_iow_n(bus.iow_n), .bus_aen(bus.aen), .bus_wdata(bus.wdata),
      .bus_rdata(bus_rdata), .bus_rdata_oe(bus_rdata_oe), .jumpers(jumpers),
      .first_port_out(first_port_out), .second_port_in(second_port_in),
      .second_port_out(second_port_out), .second_port_oe(second_port_oe),
      .third_port_in(third_port_in), .third_port_out(third_port_out),
      .third_port_oe(third_port_oe), .irq5(irq5), .irq6(irq6), .irq7(irq7), .irq9(irq9));
   isadio_host isadio_host_i (.clk_sys(clk_sys), .bus_rdata(bus_rdata),
      .bus_rdata_oe(bus_rdata_oe), .bus(bus));
   //////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // base is 0x100 plus eight per step of the two address jumpers
   function automatic logic [9:0] base_of(input logic [4:0] j);
      return 10'h100 + {5'h00, j[1:0], 3'h0};
   endfunction : base_of
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic conclude();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude
   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      #40_000;
      failures++;
      conclude();
   end
   //////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] d;
      logic v;
      arst_n = 1'b0;
      jumpers = 5'h00;
      second_port_in = 8'h00;
      third_port_in = 8'h00;
      // each of the four jumper settings in jmp gets its own reset
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_sys);
         arst_n <= 1'b0;
         jumpers <= jmp[k];
         repeat (2) @(posedge clk_sys);
         arst_n <= 1'b1;
         repeat (20) @(posedge clk_sys);
         chk("first level", first_port_out, {8{jmp[k][4]}});
         chk("dirs", {6'h00, second_port_oe[0], third_port_oe[0]},
            {6'h00, jmp[k][3], jmp[k][2]});
         chk("outs low", second_port_out | third_port_out, 8'h00);
         isadio_host_i.rd(base_of(jmp[k]), 1'b0, d, v);
         chk("board id", d, isadio_pkg::BOARD_ID);
         isadio_host_i.rd(base_of(jmp[k]) + 10'h002, 1'b0, d, v);
         chk("jumper status", d, {3'h0, jmp[k]});
         isadio_host_i.rd(base_of(jmp[k]) - 10'h001, 1'b0, d, v);
         chk("outside base", {7'h00, v}, 8'h00);
      end
      foreach (rows[i]) begin
         isadio_host_i.wr(10'h118 + {7'h00, rows[i].off}, rows[i].wd, 1'b0);
         isadio_host_i.rd(10'h118 + {7'h00, rows[i].off}, 1'b0, d, v);
         chk("readback", d, rows[i].exp);
      end
      chk("pins", first_port_out ^ second_port_out ^ third_port_out, 8'hA5);
      chk("outputs", second_port_oe & third_port_oe, 8'hFF);
      // inputs read pins; a dma cycle is ignored
      isadio_host_i.wr(10'h11C, 8'h00, 1'b0);
      second_port_in <= 8'h96;
      isadio_host_i.rd(10'h11E, 1'b0, d, v);
      chk("input pins", d, 8'h96);
      chk("inputs", second_port_oe | third_port_oe, 8'h00);
      isadio_host_i.wr(10'h11D, 8'hFF, 1'b1);
      chk("dma ignored", first_port_out, 8'h3C);
      foreach (irqs[i]) begin
         @(posedge clk_sys);
         third_port_in <= irqs[i][11:4];
         isadio_host_i.wr(10'h11B, irqs[i][19:12], 1'b0);
         chk("irq lines", {4'h0, irq5, irq6, irq7, irq9}, {4'h0, irqs[i][3:0]});
      end
      conclude();
   end
endmodule : tb
`default_nettype wire
